/* File: core/accel_spi_pkg.sv */
package accel_spi_pkg;

  // Frame geometry
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS  = 8;
  localparam int ADDR_BITS  = 6;
  localparam int AXES       = 3;
  localparam int SAMPLE_W   = 16;

  typedef logic [BYTE_BITS-1:0] byte_type;
  typedef logic [ADDR_BITS-1:0] addr_type;

  // Register map
  localparam addr_type ADDR_CONTROL = 6'h01;
  localparam addr_type ADDR_STATUS  = 6'h02;
  localparam addr_type ADDR_X_LOW   = 6'h04;
  localparam addr_type ADDR_X_HIGH  = 6'h05;
  localparam addr_type ADDR_Z_HIGH  = 6'h09;
  localparam addr_type ADDR_STEP    = 6'h01;

  // Reset values
  localparam byte_type CONTROL_RESET = 8'h00;
  localparam byte_type ZERO_BYTE     = 8'h00;

  // Fixed reply bits
  localparam logic FIXED_ZERO  = 1'b0;
  localparam logic FIXED_ONE   = 1'b1;
  localparam logic UNDEF_BIT   = 1'b0;

  // Bit counts within a byte
  localparam logic [2:0] BYTE_TOP    = 3'h7;
  localparam logic [2:0] BYTE_ALIGN  = 3'h0;

  // Command byte fields
  localparam int CMD_RW     = 1;
  localparam int CMD_ADDR_L = 2;

  // Pin synchroniser reset pattern {chip_select_low, sck, mosi}
  localparam logic [2:0] PIN_IDLE = 3'h4;

  typedef logic [AXES-1:0][SAMPLE_W-1:0] axis_set_type;
  typedef logic [AXES-1:0][BYTE_BITS-1:0] low_latch_type;

  typedef struct packed {
    logic power_reset_flag;
    logic selftest_fail_flag;
    logic saturation_flag;
  } sensor_flags_type;

  typedef struct packed {
    axis_set_type     axis;
    sensor_flags_type flags;
  } sensor_in_type;

endpackage

/* File: core/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync
  import accel_spi_pkg::*;
#(
  parameter int               WIDTH       = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // Two flip-flops per pin; only the second stage is read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage_one <= RESET_VALUE;
      sync_out  <= RESET_VALUE;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

/* File: core/reply_select.sv */
`timescale 1ns/1ns
module reply_select
  import accel_spi_pkg::*;
(
  // Lookup request
  input  wire addr_type      out_addr,
  input  wire logic          burst,
  // Register contents
  input  wire axis_set_type  snapshot,
  input  wire low_latch_type latched_low,
  input  wire byte_type      control_setting,
  input  wire logic          frame_error_flag,
  // Selected byte
  output byte_type           read_data
);

  logic     in_axis_range;
  addr_type axis_offset;
  logic [1:0] axis_index;

  assign in_axis_range = (out_addr >= ADDR_X_LOW) && (out_addr <= ADDR_Z_HIGH);
  assign axis_offset   = out_addr - ADDR_X_LOW;
  assign axis_index    = axis_offset[2:1];

  always_comb begin
    read_data = ZERO_BYTE;
    if (in_axis_range) begin
      // High byte from frozen sample, low byte from latch
      if (out_addr[0] == ADDR_X_HIGH[0]) begin
        read_data = snapshot[axis_index][SAMPLE_W-1:BYTE_BITS]; // [R15]
      end else begin
        read_data = latched_low[axis_index]; // [R16]
      end
    end else if (burst) begin
      read_data = ZERO_BYTE; // [R21]
    end else begin
      case (out_addr)
        ADDR_CONTROL: read_data = control_setting;
        ADDR_STATUS:  read_data = {{(BYTE_BITS-1){1'b0}}, frame_error_flag};
        default:      read_data = ZERO_BYTE; // [R13]
      endcase
    end
  end

endmodule

/* File: core/accel_spi_frame.sv */
`timescale 1ns/1ns
// Behaviour
// R1 - A frame is sixteen bits, two bytes, while chip select is low.
// R2 - Sample input on clock rise, change output on clock fall, clock idles low.
// R3 - Frame starts on chip select fall and ends on its rise.
// R4 - Master sends six address bits, direction bit, then address parity first.
// R5 - Address, direction and parity bits together hold an odd count of ones.
// R6 - Second byte is write data on writes, ignored on reads.
// R7 - First reply byte: error, reset, self-test, saturation, fixed bits, parity.
// R8 - Fixed reply bits are zero then one to reveal a stuck line.
// R9 - Data parity bit is odd parity of the data byte sent.
// R10 - Second reply byte is register content, or old value on writes.
// R11 - Valid writes commit at chip select rise; invalid frames change nothing.
// R12 - Read data leaves most significant bit first.
// R13 - Reserved addresses read as zero.
// R14 - Output is released while chip select is high.
// R15 - Axis samples are sixteen bits split over two registers.
// R16 - Reading an axis high byte latches its low byte.
// R17 - Master reads the high byte before the low byte.
// R18 - X high at 05, X low at 04, control at 01.
// R19 - Continued clocks after a read step the address down every byte.
// R20 - Data parity only for the first data byte of a burst.
// R21 - Bursts cover axis registers only; X low wraps to Z high.
// R22 - Axis outputs are frozen while chip select is low.
// R23 - Short frames, non byte multiples, bad address parity flag an error.
// R24 - A read with bad address parity still reads but flags an error.
// R25 - Bit counter and shifters clear on every chip select fall.
// R26 - Reported error status changes only at frame end.
module accel_spi_frame
  import accel_spi_pkg::*;
#(
  parameter int COUNT_BITS = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Serial pins
  input  wire logic          chip_select_low,
  input  wire logic          sck,
  input  wire logic          mosi,
  output logic               miso_out,
  output logic               miso_oe,
  // Sensor side
  input  wire sensor_in_type sensor,
  output byte_type           control_setting,
  output logic               frame_error_flag
);

  localparam logic [COUNT_BITS-1:0] COUNT_MAX  = '1;
  localparam logic [COUNT_BITS-1:0] COUNT_ONE  = COUNT_BITS'(1);
  localparam logic [COUNT_BITS-1:0] COUNT_ADDR = COUNT_BITS'(ADDR_BITS);
  localparam logic [COUNT_BITS-1:0] COUNT_CMD  = COUNT_BITS'(BYTE_BITS);
  localparam logic [COUNT_BITS-1:0] COUNT_FULL = COUNT_BITS'(FRAME_BITS);

  logic [2:0]            pins_sync;
  logic                  cs_s;
  logic                  sck_s;
  logic                  mosi_s;
  logic                  cs_d;
  logic                  sck_d;
  logic                  frame_start;
  logic                  frame_end;
  logic                  sck_rise;
  logic                  sck_fall;
  logic [COUNT_BITS-1:0] bit_count;
  logic [COUNT_BITS-1:0] next_count;
  byte_type              cmd;
  byte_type              wdata;
  addr_type              out_addr;
  addr_type              next_addr;
  logic                  load_pulse;
  logic                  latch_pulse;
  logic                  is_read;
  logic                  bursting;
  byte_type              data_byte;
  byte_type              lookup_data;
  byte_type              status_byte;
  logic                  tx_bit;
  logic [2:0]            tx_index;
  axis_set_type          snapshot;
  low_latch_type         latched_low;
  logic                  count_ok;
  logic                  parity_ok;
  logic                  frame_good;

  pin_sync #(
    .WIDTH       (3),
    .RESET_VALUE (PIN_IDLE)
  ) u_pin_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({chip_select_low, sck, mosi}),
    .sync_out (pins_sync)
  );

  assign cs_s   = pins_sync[2];
  assign sck_s  = pins_sync[1];
  assign mosi_s = pins_sync[0];

  // Edge detection on synchronised pins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cs_d  <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_d  <= cs_s;
      sck_d <= sck_s;
    end
  end

  assign frame_start = cs_d && !cs_s; // [R3]
  assign frame_end   = !cs_d && cs_s; // [R3]
  assign sck_rise    = !sck_d && sck_s && !cs_s; // [R2]
  assign sck_fall    = sck_d && !sck_s && !cs_s; // [R2]

  assign next_count = (bit_count == COUNT_MAX) ? bit_count
                                               : bit_count + COUNT_ONE;
  assign is_read    = !cmd[CMD_RW];
  assign bursting   = bit_count >= COUNT_FULL;

  // Bit counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bit_count <= '0;
    end else if (frame_start) begin
      bit_count <= '0; // [R25]
    end else if (sck_rise) begin
      bit_count <= next_count;
    end
  end

  // Command and write data shifters
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd   <= ZERO_BYTE;
      wdata <= ZERO_BYTE;
    end else if (frame_start) begin
      cmd   <= ZERO_BYTE; // [R25]
      wdata <= ZERO_BYTE;
    end else if (sck_rise) begin
      if (bit_count < COUNT_CMD) begin
        cmd <= {cmd[BYTE_BITS-2:0], mosi_s}; // [R4]
      end else if (bit_count < COUNT_FULL) begin
        wdata <= {wdata[BYTE_BITS-2:0], mosi_s}; // [R6]
      end
    end
  end

  // Output address, decremented per byte in a burst
  assign next_addr = (out_addr == ADDR_X_LOW) ? ADDR_Z_HIGH // [R21]
                                              : out_addr - ADDR_STEP;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_addr   <= '0;
      load_pulse <= 1'b0;
    end else begin
      load_pulse <= 1'b0;
      if (sck_rise && next_count == COUNT_ADDR) begin
        out_addr   <= {cmd[ADDR_BITS-2:0], mosi_s};
        load_pulse <= 1'b1;
      end else if (sck_rise && is_read && next_count > COUNT_FULL - COUNT_ONE
                   && next_count[2:0] == BYTE_ALIGN) begin
        out_addr   <= next_addr; // [R19]
        load_pulse <= 1'b1;
      end
    end
  end

  reply_select u_reply_select (
    .out_addr         (out_addr),
    .burst            (bursting),
    .snapshot         (snapshot),
    .latched_low      (latched_low),
    .control_setting  (control_setting),
    .frame_error_flag (frame_error_flag),
    .read_data        (lookup_data)
  );

  // Data byte for the reply; old value also serves writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_byte <= ZERO_BYTE;
    end else if (frame_start) begin
      data_byte <= ZERO_BYTE;
    end else if (load_pulse) begin
      data_byte <= lookup_data; // [R10] [R13]
    end
  end

  // Freeze samples while the frame is open
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      snapshot <= '0;
    end else if (cs_s) begin
      snapshot <= sensor.axis; // [R22]
    end
  end

  // High byte read latches the low byte of the same axis
  assign latch_pulse = sck_rise
                       && ((next_count == COUNT_CMD && !cmd[0])
                           || (bursting && is_read
                               && bit_count[2:0] == BYTE_ALIGN));

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_latch
      localparam addr_type HIGH_ADDR = ADDR_X_HIGH + addr_type'(2 * g);
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          latched_low[g] <= ZERO_BYTE;
        end else if (latch_pulse && out_addr == HIGH_ADDR) begin
          latched_low[g] <= snapshot[g][BYTE_BITS-1:0]; // [R16]
        end
      end
    end
  endgenerate

  // Status byte, sent first
  assign status_byte = {UNDEF_BIT,
                        frame_error_flag,
                        sensor.flags.power_reset_flag,
                        sensor.flags.selftest_fail_flag,
                        sensor.flags.saturation_flag,
                        FIXED_ZERO,
                        FIXED_ONE,
                        ~^data_byte}; // [R7] [R8] [R9] [R20]

  assign tx_index = BYTE_TOP - bit_count[2:0];
  assign tx_bit   = (bit_count < COUNT_CMD) ? status_byte[tx_index]
                                            : data_byte[tx_index]; // [R12]

  // Serial output changes on falling clock
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      miso_out <= 1'b0;
    end else if (frame_start) begin
      miso_out <= UNDEF_BIT;
    end else if (sck_fall) begin
      miso_out <= tx_bit; // [R2]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= !cs_s; // [R14]
    end
  end

  // Frame check at chip select rise
  assign count_ok   = (bit_count >= COUNT_FULL)
                      && (bit_count[2:0] == BYTE_ALIGN); // [R1] [R23]
  assign parity_ok  = ^cmd; // [R5]
  assign frame_good = count_ok && parity_ok;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_error_flag <= 1'b0;
    end else if (frame_end) begin
      frame_error_flag <= !frame_good; // [R23] [R24] [R26]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control_setting <= CONTROL_RESET;
    end else if (frame_end && frame_good && cmd[CMD_RW]
                 && cmd[BYTE_BITS-1:CMD_ADDR_L] == ADDR_CONTROL) begin
      control_setting <= wdata; // [R11] [R18]
    end
  end

  // Checks
  property p_release_idle;
    @(posedge clk) disable iff (!reset_n)
      $rose(cs_s) |=> !miso_oe;
  endproperty
  a_release_idle: assert property (p_release_idle) // [R14]
    else $error("miso driven after chip select rise");

  property p_fixed_zero;
    @(posedge clk) disable iff (!reset_n)
      (sck_fall && bit_count == 8'(5)) |=> !miso_out;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) // [R8]
    else $error("fixed zero bit not zero");

  property p_fixed_one;
    @(posedge clk) disable iff (!reset_n)
      (sck_fall && bit_count == 8'(6)) |=> miso_out;
  endproperty
  a_fixed_one: assert property (p_fixed_one) // [R8]
    else $error("fixed one bit not one");

  property p_data_parity;
    @(posedge clk) disable iff (!reset_n)
      (sck_fall && bit_count == 8'(7)) |=> (miso_out == ~^data_byte);
  endproperty
  a_data_parity: assert property (p_data_parity) // [R9]
    else $error("data parity bit wrong");

  property p_msb_first;
    @(posedge clk) disable iff (!reset_n)
      (sck_fall && bit_count == COUNT_CMD) |=> (miso_out == data_byte[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) // [R12]
    else $error("data not sent msb first");

  property p_short_frame;
    @(posedge clk) disable iff (!reset_n)
      (frame_end && bit_count < COUNT_FULL) |=> frame_error_flag;
  endproperty
  a_short_frame: assert property (p_short_frame) // [R23]
    else $error("short frame not flagged");

  property p_commit_only_at_end;
    @(posedge clk) disable iff (!reset_n)
      $changed(control_setting) |-> $past(frame_end && frame_good);
  endproperty
  a_commit_only_at_end: assert property (p_commit_only_at_end) // [R11]
    else $error("control changed outside a valid frame end");

  property p_frozen;
    @(posedge clk) disable iff (!reset_n)
      !$past(cs_s) |-> $stable(snapshot);
  endproperty
  a_frozen: assert property (p_frozen) // [R22]
    else $error("samples changed while frame open");

  property p_counter_clear;
    @(posedge clk) disable iff (!reset_n)
      frame_start |=> (bit_count == '0);
  endproperty
  a_counter_clear: assert property (p_counter_clear) // [R25]
    else $error("bit counter not cleared at frame start");

  property p_error_at_end;
    @(posedge clk) disable iff (!reset_n)
      $changed(frame_error_flag) |-> $past(frame_end);
  endproperty
  a_error_at_end: assert property (p_error_at_end) // [R26]
    else $error("frame error changed outside frame end");

  property p_cover_write;
    @(posedge clk) disable iff (!reset_n)
      frame_end && frame_good && cmd[CMD_RW];
  endproperty
  c_cover_write: cover property (p_cover_write);

  property p_cover_burst;
    @(posedge clk) disable iff (!reset_n)
      frame_end && frame_good && bit_count > COUNT_FULL;
  endproperty
  c_cover_burst: cover property (p_cover_burst);

  property p_cover_error;
    @(posedge clk) disable iff (!reset_n)
      frame_end && !parity_ok;
  endproperty
  c_cover_error: cover property (p_cover_error);

endmodule

/* File: verification/spi_host_model.sv */
`timescale 1ns/1ns
module spi_host_model
  import accel_spi_pkg::*;
(
  // Clock
  input  wire logic   clk,
  // Serial pins
  output logic        chip_select_low,
  output logic        sck,
  output logic        mosi,
  input  wire logic   miso_line,
  // Received reply, left aligned
  output logic [47:0] rx_bits,
  output logic        rx_valid
);
  initial begin
    chip_select_low = 1'b1;
    sck             = 1'b0;
    mosi            = 1'b0;
    rx_bits         = '0;
    rx_valid        = 1'b0;
  end

  // Command byte with odd parity over address and direction
  function automatic byte_type make_cmd(input addr_type a, input logic rw);
    make_cmd = {a, rw, ~^{a, rw}};
  endfunction

  // One framed transfer of nbits, MSB first, reply sampled while clock high
  task automatic frame(input logic [47:0] tx, input int nbits);
    logic [47:0] rx;
    rx = '0;
    @(posedge clk);
    chip_select_low <= 1'b0;
    mosi            <= tx[47];
    for (int i = 0; i < nbits; i++) begin
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      rx = {rx[46:0], miso_line};
      sck <= 1'b0;
      if (i < 47) begin
        mosi <= tx[46-i];
      end
    end
    repeat (4) @(posedge clk);
    chip_select_low <= 1'b1;
    mosi            <= ~mosi;
    rx_bits         <= rx << (48 - nbits);
    rx_valid        <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import accel_spi_pkg::*;
  logic          clk = 1'b0;
  logic          reset_n;
  logic          chip_select_low;
  logic          sck;
  logic          mosi;
  logic          miso_out;
  logic          miso_oe;
  logic          miso_line;
  logic          last_miso = 1'b0;
  sensor_in_type sensor;
  sensor_in_type frz;
  byte_type      control_setting;
  logic          frame_error_flag;
  logic [47:0]   rx_bits;
  logic          rx_valid;
  logic [47:0]   exp_q[$];
  logic [63:0]   rnd;
  byte_type      ctrl;
  byte_type      low_lat[3];
  logic          fe;
  int            err_total = 0;
  int            checks_done = 0;
  int            seed = 32'hA1F9;
  addr_type      tbl[10] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
                             6'h07, 6'h08, 6'h09, 6'h3F};

  always #10 clk = ~clk;

  accel_spi_frame #(.COUNT_BITS(8)) i_accel_spi_frame (
    .clk(clk), .reset_n(reset_n), .chip_select_low(chip_select_low),
    .sck(sck), .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe),
    .sensor(sensor), .control_setting(control_setting),
    .frame_error_flag(frame_error_flag));

  spi_host_model i_spi_host_model (
    .clk(clk), .chip_select_low(chip_select_low), .sck(sck), .mosi(mosi),
    .miso_line(miso_line), .rx_bits(rx_bits), .rx_valid(rx_valid));

  // Released line shows the inverse of its last driven level
  always @(posedge clk) if (miso_oe === 1'b1) last_miso <= miso_out;
  assign miso_line = (miso_oe === 1'b1) ? miso_out : ~last_miso;

  task automatic chk(input string what, input logic [47:0] e,
                     input logic [47:0] got);
    checks_done++;
    if (got !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("reply count", 48'h0, 48'h1);
      else chk("reply", exp_q.pop_front(), rx_bits);
    end
  end

  function automatic byte_type reg_val(input addr_type a);
    case (a)
      ADDR_CONTROL: reg_val = ctrl;
      ADDR_STATUS:  reg_val = {7'h00, fe};
      6'h04, 6'h06, 6'h08: reg_val = low_lat[(int'(a) - 4) / 2];
      6'h05, 6'h07, 6'h09: reg_val = frz.axis[(int'(a) - 5) / 2][15:8];
      default:      reg_val = ZERO_BYTE;
    endcase
  endfunction

  task automatic new_sample;
    rnd = {$random(seed), $random(seed)};
    sensor <= rnd[50:0];
    repeat (4) @(posedge clk);
  endtask

  // One frame; expectation noted before the host starts clocking
  task automatic xfer(input addr_type a, input logic rw, input logic bad,
                      input byte_type wd, input int nbits);
    byte_type    cmd;
    byte_type    d;
    addr_type    a2;
    logic [47:0] e;
    int          i;
    cmd = i_spi_host_model.make_cmd(a, rw) ^ {7'h00, bad};
    frz = sensor;
    d = reg_val(a);
    e = {1'b0, fe, frz.flags, FIXED_ZERO, FIXED_ONE, ~^d, d, 32'h0};
    if (!rw && a[0] && a >= ADDR_X_HIGH && a <= ADDR_Z_HIGH) begin
      low_lat[(int'(a) - 5) / 2] = frz.axis[(int'(a) - 5) / 2][7:0];
    end
    a2 = a;
    for (int k = 2; k < 6; k++) begin
      a2 = (a2 == ADDR_X_LOW) ? ADDR_Z_HIGH : a2 - ADDR_STEP;
      i = (int'(a2) - 4) / 2;
      if (a2 >= ADDR_X_LOW && a2 <= ADDR_Z_HIGH) begin
        e[47-8*k -: 8] = a2[0] ? frz.axis[i][15:8] : frz.axis[i][7:0];
        if (!rw && a2[0] && nbits > 8 * k) begin
          low_lat[i] = frz.axis[i][7:0];
        end
      end
    end
    e = e & ~(48'hFFFFFFFFFFFF >> nbits);
    exp_q.push_back(e);
    i_spi_host_model.frame({cmd, wd, 32'h0}, nbits);
    fe = bad || nbits < 16 || (nbits % 8) != 0;
    if (rw && !fe && a == ADDR_CONTROL) ctrl = wd;
    @(negedge clk);
    chk("control_setting", ctrl, control_setting);
    chk("frame_error_flag", fe, frame_error_flag);
    chk("miso_oe", 1'b0, miso_oe);
  endtask

  initial begin
    reset_n = 1'b0;
    sensor = '0;
    ctrl = CONTROL_RESET;
    fe = 1'b0;
    low_lat = '{default: 8'h00};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("reset outputs", {ctrl, fe, 1'b0}, {control_setting,
        frame_error_flag, miso_oe});
    foreach (tbl[n]) xfer(tbl[n], 1'b0, 1'b0, 8'hA5, 16);
    for (int ax = 0; ax < AXES; ax++) begin
      new_sample();
      xfer(addr_type'(5 + 2 * ax), 1'b0, 1'b0, 8'h3C, 16);
      new_sample();
      xfer(addr_type'(4 + 2 * ax), 1'b0, 1'b0, 8'hC3, 16);
    end
    xfer(ADDR_CONTROL, 1'b1, 1'b0, rnd[7:0], 16);
    xfer(ADDR_CONTROL, 1'b1, 1'b1, ~rnd[7:0], 16);
    xfer(ADDR_STATUS, 1'b0, 1'b0, 8'h00, 16);
    xfer(ADDR_X_HIGH, 1'b0, 1'b1, 8'h00, 16);
    xfer(ADDR_CONTROL, 1'b1, 1'b0, 8'h5A, 12);
    xfer(ADDR_CONTROL, 1'b0, 1'b0, 8'h00, 20);
    xfer(ADDR_X_LOW, 1'b1, 1'b0, 8'hFF, 16);
    new_sample();
    fork
      xfer(ADDR_X_HIGH, 1'b0, 1'b0, 8'h00, 40);
      begin
        repeat (60) @(posedge clk);
        new_sample();
      end
    join
    xfer(6'h06, 1'b0, 1'b0, 8'h00, 48);
    for (int n = 0; n < 8; n++) begin
      new_sample();
      xfer(tbl[rnd[35:32] % 10], rnd[40], 1'b0, rnd[7:0], 16);
    end
    chk("pending replies", 48'h0, 48'(exp_q.size()));
    wrap_up();
  end

  initial begin
    #(20 * 30000);
    err_total++;
    wrap_up();
  end
endmodule
